// [dts_sequencer.sv]
// dram transaction sequencer with its write data fifo
`include "dts_defines.svh"

module dts_fifo #(
  parameter int WIDTH = `DTS_DW_W,
  parameter int DEPTH = `DTS_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;
  assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
  property p_fifo_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      out_valid && !out_ready |=> $stable(out_data) && out_valid;
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("fifo head changed while stalled");
endmodule

module dts_sequencer
  import dts_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dwmode,
  input wire logic [4:0] lzpwait,
  input wire logic seed_wr,
  input wire logic [14:0] seed_val,
  input wire logic castout_cache_update,
  input wire dts_pkg::dts_req_t req,
  output logic req_ready,
  input wire logic cpu_wd_valid,
  input wire logic [63:0] cpu_wd,
  output logic cpu_wd_ready,
  input wire logic dma_wd_valid,
  input wire logic [63:0] dma_wd,
  output logic dma_wd_ready,
  input wire logic [127:0] dram_rdata,
  output logic [3:0] ras,
  output logic [3:0] cas,
  output logic [13:0] dram_addr,
  output logic dram_addr_lo,
  output logic [1:0] dram_write_strobe,
  output logic dram_oe,
  output dts_pkg::dts_pad_t pad,
  output logic pad_oe,
  output dts_pkg::dts_rd_t rd,
  output logic l2_invalidate,
  output logic l2_line_update,
  output logic l2_wdata_valid,
  output logic refresh_pending
);
  import dts_pkg::*;

  function automatic logic partial(input dts_req_t t);
    partial = t.op == DTS_OP_FZ ||
      (t.op == DTS_OP_WR && t.be != `DTS_BE_FULL);
  endfunction
  function automatic logic needs_rd(input dts_req_t t);
    needs_rd = t.op == DTS_OP_RD || partial(t);
  endfunction
  function automatic logic [7:0] ecc8(input logic [63:0] d);
    logic [7:0] e;
    e = '0;
    for (int i = 0; i < 8; i++) begin
      e[i] = ^d[8*i +: 8];
    end
    ecc8 = e;
  endfunction
  function automatic logic [63:0] merge(input logic [63:0] nw,
    input logic [63:0] old, input logic [7:0] be);
    logic [63:0] m;
    m = old;
    for (int i = 0; i < 8; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = m;
  endfunction
  function automatic logic [3:0] cyc(input dts_state_t s);
    case (s)
      DTS_RAS: cyc = 4'(`DTS_TRCD_CYC - 1);
      DTS_CASRD: cyc = 4'(`DTS_TCAS_CYC - 1);
      DTS_CASWR: cyc = 4'(`DTS_TCAS_CYC - 1);
      DTS_TURN: cyc = 4'(`DTS_TTURN_CYC - 1);
      DTS_WSET: cyc = 4'(`DTS_TWS_CYC - 1);
      DTS_PRE: cyc = 4'(`DTS_TRP_CYC - 1);
      DTS_REFC: cyc = 4'(`DTS_TCSR_CYC - 1);
      DTS_REFR: cyc = 4'(`DTS_TREF_CYC - 1);
      default: cyc = 4'h0;
    endcase
  endfunction

  dts_state_t state_r;
  dts_state_t state_nxt;
  dts_state_t pick;
  dts_req_t cur_r;
  dts_req_t vw;
  logic cur_live_r;
  logic ras_open_r;
  logic last_rd_r;
  logic rmw_phase_r;
  logic ref_pend_r;
  logic hold_r;
  logic [14:0] rcnt_r;
  logic [14:0] seed_r;
  logic [19:0] page_r;
  logic [3:0] rsel_r;
  logic [3:0] csel_r;
  logic [3:0] tmr_r;
  logic [4:0] idle_cnt_r;
  logic [2:0] beat_r;
  logic [2:0] fill_r;
  logic [63:0] rmw_buf_r;
  logic [63:0] st_r [2];
  logic [1:0] st_cnt_r;
  logic [2:0] step;
  logic [2:0] dws;
  logic [2:0] rem;
  logic [1:0] idx;
  logic [1:0] wneed;
  logic [1:0] halves;
  logic tend;
  logic done;
  logic keep;
  logic vlive;
  logic take;
  logic issue_rd;
  logic lzp_close;
  logic rc_ovf;
  logic stage_ok;
  logic st_load;
  logic fslot;
  logic wslot;
  logic last_beat;
  logic fill_en;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic [63:0] f_in_data;
  logic [63:0] f_out_data;
  logic [63:0] w0;
  logic [63:0] w1;
  logic [7:0] mbe;

  assign step = dwmode ? 3'h2 : 3'h1;
  assign dws = {1'b0, cur_r.ndw_m1} + 3'h1;
  assign rem = dws - beat_r;
  assign last_beat = (beat_r + step) >= dws;
  assign tend = tmr_r == 4'h0;
  assign done = tend && ((state_r == DTS_CASRD && !rmw_phase_r &&
    last_beat) || (state_r == DTS_CASWR && last_beat));
  assign keep = cur_live_r && !done;
  assign vlive = keep || req.valid;
  assign vw = keep ? cur_r : req;
  assign req_ready = !cur_live_r || done;
  assign take = req.valid && req_ready;
  assign issue_rd = keep ? (cur_r.op == DTS_OP_RD || rmw_phase_r) :
    needs_rd(req);
  assign lzp_close = lzpwait == `DTS_LZP_EAGER ||
    (lzpwait != `DTS_LZP_LAZY && idle_cnt_r >= lzpwait);

  // choice made in idle and at the end of each transaction
  always_comb begin
    if (ref_pend_r) begin
      pick = ras_open_r ? DTS_PRE : DTS_REFC;
    end else if (vlive) begin
      if (!ras_open_r) begin
        pick = DTS_RAS;
      end else if (vw.addr[`DTS_PAGE_HI:`DTS_PAGE_LO] != page_r) begin
        pick = DTS_PRE;
      end else if (issue_rd) begin
        pick = DTS_CASRD;
      end else if (last_rd_r) begin
        pick = DTS_TURN;
      end else begin
        pick = DTS_WSET;
      end
    end else if (ras_open_r && lzp_close) begin
      pick = DTS_PRE;
    end else begin
      pick = DTS_IDLE;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DTS_IDLE: state_nxt = pick;
      DTS_RAS: if (tend) state_nxt = issue_rd ? DTS_CASRD : DTS_WSET;
      DTS_CASRD: begin
        if (tend) begin
          if (rmw_phase_r) begin
            state_nxt = DTS_TURN;
          end else if (!last_beat) begin
            state_nxt = DTS_CASRD;
          end else begin
            state_nxt = pick;
          end
        end
      end
      DTS_TURN: if (tend) state_nxt = DTS_WSET;
      DTS_WSET: if (tend && stage_ok) state_nxt = DTS_CASWR;
      DTS_CASWR: if (tend) state_nxt = last_beat ? pick : DTS_WSET;
      DTS_PRE: if (tend) state_nxt = pick;
      DTS_REFC: if (tend) state_nxt = DTS_REFR;
      DTS_REFR: if (tend) state_nxt = DTS_PRE;
      default: state_nxt = DTS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= DTS_IDLE;
      tmr_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || tend) begin
        tmr_r <= cyc(state_nxt);
      end else begin
        tmr_r <= tmr_r - 4'h1;
      end
    end
  end

  // transaction record and phase tracking
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_r <= '0;
      cur_live_r <= 1'b0;
      rmw_phase_r <= 1'b0;
      beat_r <= 3'h0;
    end else begin
      cur_live_r <= take || keep;
      if (take) begin
        cur_r <= req;
        if (req.op == DTS_OP_FZ) begin
          cur_r.be <= req.addr[`DTS_ORDER_BIT] ?
            `DTS_BE_WORD_LO : `DTS_BE_WORD_HI;
        end
        rmw_phase_r <= partial(req);
        beat_r <= 3'h0;
      end else if (tend && state_r == DTS_CASRD && rmw_phase_r) begin
        rmw_phase_r <= 1'b0;
        beat_r <= 3'h0;
      end else if (tend && (state_r == DTS_CASRD ||
          state_r == DTS_CASWR)) begin
        beat_r <= beat_r + step;
      end
    end
  end

  // row state, page compare and close timer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ras_open_r <= 1'b0;
      page_r <= '0;
      rsel_r <= 4'h0;
      csel_r <= 4'h0;
      last_rd_r <= 1'b0;
      idle_cnt_r <= 5'h00;
    end else begin
      if (state_nxt == DTS_RAS && state_r != DTS_RAS) begin
        ras_open_r <= 1'b1;
        page_r <= vw.addr[`DTS_PAGE_HI:`DTS_PAGE_LO];
        rsel_r <= vw.row_sel;
        csel_r <= vw.col_sel;
      end else if (state_nxt == DTS_PRE) begin
        ras_open_r <= 1'b0;
      end
      if (state_r == DTS_CASRD) begin
        last_rd_r <= 1'b1;
      end else if (state_r == DTS_CASWR || state_r == DTS_PRE) begin
        last_rd_r <= 1'b0;
      end
      if (state_r == DTS_CASRD || state_r == DTS_CASWR) begin
        idle_cnt_r <= 5'h00;
      end else if (idle_cnt_r != `DTS_LZP_LAZY) begin
        idle_cnt_r <= idle_cnt_r + 5'h01;
      end
    end
  end

  // refresh counter; the hold cycle after reload adds the second clock
  assign rc_ovf = rcnt_r == `DTS_RCNT_MAX && !hold_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rcnt_r <= `DTS_SEED_RST;
      seed_r <= `DTS_SEED_RST;
      hold_r <= 1'b0;
      ref_pend_r <= 1'b0;
    end else begin
      if (seed_wr) begin
        seed_r <= seed_val;
        rcnt_r <= seed_val;
        hold_r <= 1'b0;
      end else if (rc_ovf) begin
        rcnt_r <= seed_r;
        hold_r <= 1'b1;
      end else if (hold_r) begin
        hold_r <= 1'b0;
      end else begin
        rcnt_r <= rcnt_r + 15'h0001;
      end
      // a new overflow wins over the clear at refresh start
      if (rc_ovf && !seed_wr) begin
        ref_pend_r <= 1'b1;
      end else if (state_r != DTS_REFC && state_nxt == DTS_REFC) begin
        ref_pend_r <= 1'b0;
      end
    end
  end
  assign refresh_pending = ref_pend_r;

  // write data: queue select, fifo, staging, merge, ecc
  assign fill_en = cur_live_r && cur_r.op == DTS_OP_WR && fill_r < dws;
  assign f_in_valid = fill_en &&
    (cur_r.src == DTS_SRC_DMA ? dma_wd_valid : cpu_wd_valid);
  assign f_in_data = cur_r.src == DTS_SRC_DMA ? dma_wd : cpu_wd;
  assign cpu_wd_ready = fill_en && cur_r.src == DTS_SRC_CPU && f_in_ready;
  assign dma_wd_ready = fill_en && cur_r.src == DTS_SRC_DMA && f_in_ready;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || take) begin
      fill_r <= 3'h0;
    end else if (f_in_valid && f_in_ready) begin
      fill_r <= fill_r + 3'h1;
    end
  end

  dts_fifo #(.WIDTH(64), .DEPTH(`DTS_FIFO_DEPTH)) u_wfifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(st_load)
  );

  assign wneed = (dwmode && rem >= 3'h2) ? 2'h2 : 2'h1;
  assign halves = wneed == 2'h2 ? 2'b11 : 2'b01;
  assign stage_ok = cur_r.op == DTS_OP_FZ || st_cnt_r == wneed;
  assign st_load = cur_live_r && cur_r.op == DTS_OP_WR &&
    st_cnt_r < wneed && state_r != DTS_CASWR &&
    !(state_r == DTS_WSET && state_nxt == DTS_CASWR) && f_out_valid;
  assign wslot = st_cnt_r[0] ^ (dwmode && cur_r.castout &&
    cur_r.addr[`DTS_ORDER_BIT]);
  assign fslot = dwmode && !(cur_r.ndw_m1[0] ^ beat_r[0]);
  assign mbe = cur_r.op == DTS_OP_FZ ? cur_r.be : cur_r.be;
  always_comb begin
    w0 = st_r[0];
    w1 = dwmode ? st_r[1] : 64'h0000000000000000;
    if (partial(cur_r) && last_beat) begin
      if (fslot) begin
        w1 = merge(cur_r.op == DTS_OP_FZ ? 64'h0 : st_r[1],
          rmw_buf_r, mbe);
      end else begin
        w0 = merge(cur_r.op == DTS_OP_FZ ? 64'h0 : st_r[0],
          rmw_buf_r, mbe);
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_cnt_r <= 2'h0;
      st_r[0] <= '0;
      st_r[1] <= '0;
      pad <= '0;
    end else begin
      if (state_r == DTS_WSET && state_nxt == DTS_CASWR) begin
        st_cnt_r <= 2'h0;
        pad.data <= {w0, w1};
        pad.ecc <= {ecc8(w0), dwmode ? ecc8(w1) : 8'h00};
      end else if (st_load) begin
        st_r[wslot] <= f_out_data;
        st_cnt_r <= st_cnt_r + 2'h1;
      end
    end
  end

  // read return and merge capture; sub-word requests still get a dw
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd <= '0;
      rmw_buf_r <= '0;
    end else begin
      rd.valid <= 1'b0;
      if (state_r == DTS_CASRD && tend) begin
        if (rmw_phase_r) begin
          rmw_buf_r <= dram_rdata[127:64];
        end
        if (cur_r.op != DTS_OP_WR) begin
          rd.valid <= 1'b1;
          rd.two <= dwmode && cur_r.op == DTS_OP_RD && rem >= 3'h2;
          rd.data <= dram_rdata;
        end
      end
    end
  end

  // l2 coherence pulses at write acceptance
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      l2_invalidate <= 1'b0;
      l2_line_update <= 1'b0;
    end else begin
      l2_line_update <= take && req.op == DTS_OP_WR && req.castout &&
        req.src == DTS_SRC_CPU && castout_cache_update;
      l2_invalidate <= take && req.op != DTS_OP_RD && !(req.castout &&
        req.src == DTS_SRC_CPU && castout_cache_update);
    end
  end

  // pins
  assign idx = rmw_phase_r ? cur_r.addr[4:3] + cur_r.ndw_m1 :
    (cur_r.addr[4:3] + beat_r[1:0]) ^ {1'b0, !dwmode && cur_r.castout &&
    cur_r.addr[`DTS_ORDER_BIT]};
  assign ras = (state_r == DTS_REFR) ? 4'hF :
    (ras_open_r ? rsel_r : 4'h0);
  assign cas = (state_r == DTS_REFC || state_r == DTS_REFR) ? 4'hF :
    ((state_r == DTS_CASRD || state_r == DTS_CASWR) ? csel_r : 4'h0);
  assign dram_addr = state_r == DTS_RAS ? cur_r.row :
    (dwmode ? {cur_r.col[13:1], idx[1] ^ idx[0]} :
    {cur_r.col[13:2], idx});
  assign dram_addr_lo = idx[1];
  assign dram_write_strobe = (state_r == DTS_WSET ||
    state_r == DTS_CASWR) ? halves : 2'b00;
  assign dram_oe = state_r == DTS_CASRD;
  assign pad_oe = state_r == DTS_CASWR;
  assign l2_wdata_valid = state_r == DTS_CASWR;

  sequence s_cbr;
    (cas == 4'hF && ras == 4'h0) [*2] ##1 (cas == 4'hF && ras == 4'hF);
  endsequence
  property p_ref_seq;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(state_r == DTS_REFC) |-> s_cbr;
  endproperty
  a_ref_seq: assert property (p_ref_seq)
    else $error("refresh not cas before ras");
  property p_early_wr;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(|cas) && |dram_write_strobe |-> $past(|dram_write_strobe);
  endproperty
  a_early_wr: assert property (p_early_wr)
    else $error("write strobe not ahead of cas");
  property p_reload;
    @(posedge clk_sys) disable iff (!rst_n)
      rc_ovf && !seed_wr |=> rcnt_r == $past(seed_r) && ref_pend_r;
  endproperty
  a_reload: assert property (p_reload)
    else $error("no seed reload on overflow");
  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      rc_ovf && !seed_wr ##1 !seed_wr |=> rcnt_r == $past(rcnt_r, 1);
  endproperty
  a_hold: assert property (p_hold)
    else $error("refresh interval short by one");
  property p_seed;
    @(posedge clk_sys) disable iff (!rst_n)
      seed_wr |=> rcnt_r == $past(seed_val);
  endproperty
  a_seed: assert property (p_seed)
    else $error("seed write did not load counter");
  property p_turn;
    @(posedge clk_sys) disable iff (!rst_n)
      state_r == DTS_CASRD ##1 state_r != DTS_CASRD |->
        state_r != DTS_WSET;
  endproperty
  a_turn: assert property (p_turn)
    else $error("read to write without turnaround");
  property p_lazy;
    @(posedge clk_sys) disable iff (!rst_n)
      state_r == DTS_IDLE && lzpwait == `DTS_LZP_LAZY &&
        !vlive && !ref_pend_r |=> ras_open_r == $past(ras_open_r);
  endproperty
  a_lazy: assert property (p_lazy)
    else $error("lazy policy closed the page");
  property p_eager;
    @(posedge clk_sys) disable iff (!rst_n)
      state_r == DTS_IDLE && lzpwait == `DTS_LZP_EAGER && ras_open_r &&
        !vlive |=> state_r == DTS_PRE;
  endproperty
  a_eager: assert property (p_eager)
    else $error("eager policy kept the page");
  property p_width;
    @(posedge clk_sys) disable iff (!rst_n)
      rd.valid && rd.two |-> dwmode;
  endproperty
  a_width: assert property (p_width)
    else $error("two doublewords in narrow mode");
  property p_beats;
    @(posedge clk_sys) disable iff (!rst_n)
      state_r == DTS_CASWR |-> beat_r < dws;
  endproperty
  a_beats: assert property (p_beats)
    else $error("cas beyond transaction size");
endmodule

// [dts_defines.svh]
// constants of the dram transaction sequencer
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH
`define DTS_CLK_MHZ 200
`define DTS_CYC(ns) ((ns * `DTS_CLK_MHZ + 999) / 1000)
`define DTS_TRP_NS 30
`define DTS_TRP_CYC `DTS_CYC(`DTS_TRP_NS)
`define DTS_TRCD_NS 20
`define DTS_TRCD_CYC `DTS_CYC(`DTS_TRCD_NS)
`define DTS_TCAS_NS 15
`define DTS_TCAS_CYC `DTS_CYC(`DTS_TCAS_NS)
`define DTS_TWS_NS 5
`define DTS_TWS_CYC `DTS_CYC(`DTS_TWS_NS)
`define DTS_TTURN_NS 10
`define DTS_TTURN_CYC `DTS_CYC(`DTS_TTURN_NS)
`define DTS_TCSR_NS 10
`define DTS_TCSR_CYC `DTS_CYC(`DTS_TCSR_NS)
`define DTS_TREF_NS 60
`define DTS_TREF_CYC `DTS_CYC(`DTS_TREF_NS)
`define DTS_LZP_EAGER 5'h00
`define DTS_LZP_LAZY 5'h1F
`define DTS_RCNT_MAX 15'h7FFF
`define DTS_SEED_RST 15'h0000
`define DTS_BE_FULL 8'hFF
`define DTS_BE_WORD_HI 8'hF0
`define DTS_BE_WORD_LO 8'h0F
`define DTS_ORDER_BIT 2
`define DTS_DWIDX_HI 4
`define DTS_DWIDX_LO 3
`define DTS_PAGE_HI 31
`define DTS_PAGE_LO 12
`define DTS_FIFO_DEPTH 16
`define DTS_DW_W 64
`endif

// [dts_pkg.sv]
// types of the dram transaction sequencer
package dts_pkg;
  typedef enum logic [1:0] {
    DTS_OP_RD = 2'b00,
    DTS_OP_WR = 2'b01,
    DTS_OP_FZ = 2'b10
  } dts_op_t;
  typedef enum logic {
    DTS_SRC_CPU = 1'b0,
    DTS_SRC_DMA = 1'b1
  } dts_src_t;
  typedef enum logic [3:0] {
    DTS_IDLE = 4'h0,
    DTS_RAS = 4'h1,
    DTS_CASRD = 4'h2,
    DTS_TURN = 4'h3,
    DTS_WSET = 4'h4,
    DTS_CASWR = 4'h5,
    DTS_PRE = 4'h6,
    DTS_REFC = 4'h7,
    DTS_REFR = 4'h8
  } dts_state_t;
  typedef struct packed {
    logic valid;
    dts_src_t src;
    dts_op_t op;
    logic castout;
    logic [1:0] ndw_m1;
    logic [7:0] be;
    logic [31:0] addr;
    logic [13:0] row;
    logic [13:0] col;
    logic [3:0] row_sel;
    logic [3:0] col_sel;
  } dts_req_t;
  typedef struct packed {
    logic valid;
    logic two;
    logic [127:0] data;
  } dts_rd_t;
  typedef struct packed {
    logic [127:0] data;
    logic [15:0] ecc;
  } dts_pad_t;
endpackage

// [dts_dram_model.sv]
// behavioural dram banks on the multiplexed bus
module dts_dram_model (
  input wire logic clk_sys,
  input wire logic [3:0] ras,
  input wire logic [3:0] cas,
  input wire logic [13:0] dram_addr,
  input wire logic [1:0] dram_write_strobe,
  input wire logic dram_oe,
  input wire logic [127:0] pad_data,
  output logic [127:0] dram_rdata,
  output logic bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [127:0] mem [16];
  logic [127:0] last = '0;
  logic [3:0] cas_q = 4'h0;
  logic [1:0] ws_q = 2'h0;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = {8{12'hA5C, i[3:0]}};
    end
  end
  // released bus shows the inverse, so a stale sample cannot pass
  assign dram_rdata = dram_oe ? mem[dram_addr[3:0]] : ~last;
  always @(posedge clk_sys) begin
    cas_q <= cas;
    ws_q <= dram_write_strobe;
    if (dram_oe) last <= mem[dram_addr[3:0]];
    if (|cas && dram_write_strobe[0]) begin
      mem[dram_addr[3:0]][127:64] <= pad_data[127:64];
    end
    if (|cas && dram_write_strobe[1]) begin
      mem[dram_addr[3:0]][63:0] <= pad_data[63:0];
    end
    bad <= (cas_q == 4'h0 && |cas && |dram_write_strobe &&
      ws_q == 2'h0) ||
      (cas == 4'hF && cas_q != 4'hF && |ras);
  end
endmodule

// [tb_dram_transaction_sequencer.sv]
// self-checking bench for the sequencer, its write fifo and dram banks
module tb_dram_transaction_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import dts_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dwmode = 1'b0;
  logic seed_wr = 1'b0;
  logic castout_cache_update = 1'b1;
  logic cpu_wd_valid = 1'b0;
  logic dma_wd_valid = 1'b0;
  logic [4:0] lzpwait = 5'h1F;
  logic [14:0] seed_val = 15'h0000;
  logic [63:0] cpu_wd = 64'h0, dma_wd = 64'h0, cur, d;
  dts_req_t req = '0;
  logic req_ready, cpu_wd_ready, dma_wd_ready, dram_addr_lo, dram_oe, pad_oe;
  logic l2_invalidate, l2_line_update, l2_wdata_valid, refresh_pending, bad;
  logic [127:0] dram_rdata;
  logic [3:0] ras, cas;
  logic [3:0] ras_q = 4'h0;
  logic [13:0] dram_addr;
  logic [1:0] dram_write_strobe;
  dts_pad_t pad;
  dts_rd_t rd;
  logic rp_q = 1'b0, co = 1'b0;
  logic [1:0] ndw = 2'h0;
  logic [63:0] exp_q [$], fq [$];
  int error_cnt = 0, n_tests = 0, falls = 0, invs = 0, rises = 0, n;
  int wvs = 0, lups = 0;
  time rise_t = 0, gap = 0;
  dts_sequencer uut (.clk_sys, .rst_n, .dwmode, .lzpwait, .seed_wr, .seed_val,
    .castout_cache_update, .req, .req_ready, .cpu_wd_valid, .cpu_wd,
    .cpu_wd_ready, .dma_wd_valid, .dma_wd, .dma_wd_ready, .dram_rdata, .ras,
    .cas, .dram_addr, .dram_addr_lo, .dram_write_strobe, .dram_oe, .pad,
    .pad_oe, .rd, .l2_invalidate, .l2_line_update, .l2_wdata_valid,
    .refresh_pending);
  dts_dram_model banks (.clk_sys, .ras, .cas, .dram_addr, .dram_write_strobe,
    .dram_oe, .pad_data(pad.data), .dram_rdata, .bad);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // byte parity of one doubleword, as the ecc lanes should carry it
  function automatic logic [7:0] par(input logic [63:0] v);
    for (int i = 0; i < 8; i++) par[i] = ^v[8*i +: 8];
  endfunction
  // results are judged at the falling edge, away from the launching edge
  always @(negedge clk_sys) begin
    if (ras_q != 4'h0 && ras == 4'h0) falls++;
    if (refresh_pending === 1'b1 && !rp_q) begin
      rises++;
      gap = $time - rise_t;
      rise_t = $time;
    end
    ras_q = ras;
    rp_q = refresh_pending;
    if (l2_invalidate === 1'b1) invs++;
    if (l2_line_update === 1'b1) lups++;
    if (l2_wdata_valid === 1'b1) wvs++;
    if (bad === 1'b1) chk(64'h0, 64'h1);
    if (rd.valid === 1'b1) chk(exp_q.pop_front(), rd.data[127:64]);
    if (pad_oe === 1'b1) begin
      chk(64'(pad.ecc), 64'({par(pad.data[127:64]), 8'h00}));
      chk(64'(l2_wdata_valid), 64'h1);
    end
  end
  task automatic hs_wait(input int w);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if ((w == 0 && req_ready === 1'b1) || (w == 1 && cpu_wd_ready === 1'b1)
        || (w == 2 && dma_wd_ready === 1'b1)) break;
    end
    if (i == 400) chk(64'h0, 64'h1);
  endtask
  task automatic issue(input dts_op_t op, input logic [3:0] c,
      input logic [7:0] be, input dts_src_t s);
    @(posedge clk_sys);
    #1;
    req = '{1'b1, s, op, co, ndw, be, {20'h00012, 3'h0, c, 2'b00, co, 2'b00},
      14'h0012, {10'h0, c}, 4'h1, 4'h1};
    hs_wait(0);
    #1;
    req.valid = 1'b0;
  endtask
  task automatic push(input dts_src_t s, input logic [63:0] v);
    @(posedge clk_sys);
    #1;
    cpu_wd = v;
    dma_wd = v;
    cpu_wd_valid = (s == DTS_SRC_CPU);
    dma_wd_valid = (s == DTS_SRC_DMA);
    hs_wait(s == DTS_SRC_DMA ? 2 : 1);
    #1;
    cpu_wd_valid = 1'b0;
    dma_wd_valid = 1'b0;
    cpu_wd = ~v;
    dma_wd = ~v;
  endtask
  task automatic wr(input logic [3:0] c, input logic [7:0] be,
      input dts_src_t s, input logic [63:0] v);
    fork
      issue(DTS_OP_WR, c, be, s);
      push(s, v);
    join
  endtask
  task automatic rd_op(input dts_op_t op, input logic [3:0] c,
      input logic [63:0] e);
    exp_q.push_back(e);
    issue(op, c, 8'hFF, DTS_SRC_CPU);
  endtask
  task automatic drain();
    for (n = 0; n < 400 && exp_q.size() != 0; n++) @(posedge clk_sys);
    #1;
    chk(64'(exp_q.size()), 64'h0);
  endtask
  task automatic seed_pulse();
    @(posedge clk_sys);
    #1;
    seed_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    seed_wr = 1'b0;
  endtask
  function automatic logic [63:0] merge(input logic [63:0] o,
      input logic [63:0] v, input logic [7:0] be);
    for (int i = 0; i < 8; i++) if (be[i]) o[8*i +: 8] = v[8*i +: 8];
    return o;
  endfunction
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    void'($urandom(95755));
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk({55'h0, req_ready, ras, cas}, 64'h100);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      dwmode = m[0];
      // wide mode drops the column lsb, so use even columns only
      cur = {4{12'hA5C, 4'h8 + {m[2:0], 1'b0}}};
      rd_op(DTS_OP_RD, cur[3:0], cur);
      drain();
    end
    dwmode = 1'b0;
    $display("test width done");
    falls = 0;
    invs = 0;
    cur = {$urandom, $urandom};
    wr(4'h1, 8'hFF, DTS_SRC_CPU, cur);
    rd_op(DTS_OP_RD, 4'h1, cur);
    d = {$urandom, $urandom};
    wr(4'h1, 8'h0F, DTS_SRC_DMA, d);
    cur = merge(cur, d, 8'h0F);
    rd_op(DTS_OP_FZ, 4'h1, cur);
    rd_op(DTS_OP_RD, 4'h1, {32'h0, cur[31:0]});
    drain();
    chk(64'(falls), 64'h0);
    chk(64'(invs), 64'h3);
    repeat (40) @(posedge clk_sys);
    #1;
    chk(64'(ras), 64'h1);
    lzpwait = 5'h00;
    rd_op(DTS_OP_RD, 4'hC, {4{12'hA5C, 4'hC}});
    drain();
    repeat (20) @(posedge clk_sys);
    chk(64'(ras), 64'h0);
    $display("test chain done");
    seed_val = ~15'd198;
    seed_pulse();
    rises = 0;
    repeat (450) @(posedge clk_sys);
    chk(64'(gap), 64'd1000);
    chk(64'(rises), 64'h2);
    rises = 0;
    repeat (6) begin
      seed_pulse();
      repeat (150) @(posedge clk_sys);
    end
    chk(64'(rises), 64'h0);
    $display("test refresh done");
    // four-doubleword castout in swapped order goes through the queue
    wvs = 0;
    ndw = 2'h3;
    co = 1'b1;
    fork
      issue(DTS_OP_WR, 4'h4, 8'hFF, DTS_SRC_CPU);
      repeat (4) begin
        fq.push_back({$urandom, $urandom});
        push(DTS_SRC_CPU, fq[$]);
      end
    join
    chk(64'(cpu_wd_ready), 64'h0);
    co = 1'b0;
    for (int k = 0; k < 3; k++) exp_q.push_back(fq[k ^ 1]);
    rd_op(DTS_OP_RD, 4'h4, fq[2]);
    drain();
    ndw = 2'h0;
    chk(64'(wvs), 64'd12);
    chk(64'(invs), 64'h3);
    chk(64'(lups), 64'h1);
    $display("test queue done");
    conclude();
  end
endmodule
